// [hdl/ptj_defs.svh]
// addresses, reset values, ranges and timing of the profile target and jerk setup block
`ifndef PTJ_DEFS_SVH
`define PTJ_DEFS_SVH
`define PTJ_ADDR_DEN   16'h060E
`define PTJ_ADDR_NUM   16'h0610
`define PTJ_ADDR_JERK  16'h061A
`define PTJ_ADDR_PPS   16'h0620
`define PTJ_ADDR_ABS   16'h0622
`define PTJ_ADDR_RELM  16'h0624
`define PTJ_ADDR_RELT  16'h0626
`define PTJ_ADDR_PVS   16'h0628
`define PTJ_ADDR_STAT  16'h062A
`define PTJ_ADDR_TGT   16'h062C
`define PTJ_ADDR_LMAX  16'h062E
`define PTJ_ADDR_LMIN  16'h0630
`define PTJ_NUM_RST    32'h0000_0001
`define PTJ_DEN_RST    32'h0000_0001
`define PTJ_PPS_RST    16'h003C
`define PTJ_PPS_MIN    32'h0000_0001
`define PTJ_SPD_MAX    32'h0000_3390
`define PTJ_SPD_NEG    32'hFFFF_CC70
`define PTJ_JERK_RST   16'h0000
`define PTJ_JERK_MAX   16'h0080
`define PTJ_POS_MAX    32'h7FFF_FFFF
`define PTJ_TICK_NS    1000000
`define PTJ_CLK_NS     100
`endif

// [hdl/ptj_pkg.sv]
// types shared by the profile target and jerk setup block
package ptj_pkg;
    // operating modes seen from the mode manager
    typedef enum logic [2:0] {
        MODE_NONE = 3'h0,
        MODE_PP   = 3'h1,
        MODE_JOG  = 3'h2,
        MODE_PV   = 3'h3,
        MODE_HOME = 3'h6
    } ptj_mode_type;
    // parameter access request from the fieldbus side
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } ptj_req_type;
    // parameter access answer
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } ptj_rsp_type;
    // state of the setup block apart from the sample memory
    typedef struct packed {
        ptj_rsp_type        rsp;
        logic [31:0]        num;
        logic [31:0]        den;
        logic               apply;
        logic [15:0]        jerk;
        logic [15:0]        pps;
        logic [15:0]        pvs;
        logic [15:0]        pps_eff;
        logic [15:0]        pvs_eff;
        logic [31:0]        abs_t;
        logic [31:0]        relm;
        logic [31:0]        relt;
        logic [31:0]        target;
        logic               start;
        logic               zero;
        logic [31:0]        lim_max;
        logic [31:0]        lim_min;
        logic signed [39:0] sum;
        logic [15:0]        tick_cnt;
        logic [6:0]         wptr;
        logic [31:0]        smooth;
    } ptj_state_type;
    // index of the highest set bit, used for scaling and jerk window
    function automatic logic [4:0] ptj_msb(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction
endpackage

// [hdl/ptj_delay_mem.sv]
// sample memory of the jerk smoothing window, registered read
`timescale 1ns/1ps
`default_nettype none
module ptj_delay_mem #(
    parameter int W  = 32,
    parameter int AW = 7
) (
    input  wire logic          clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [W-1:0]  wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output var  logic [W-1:0]  rd_data_out
);
    logic [W-1:0] mem [2**AW];

    // storage write
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // read data always from a register, old content on a same-cycle write
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule // ptj_delay_mem
`default_nettype wire

// [hdl/ptj_clamp.sv]
// limits a signed speed to a magnitude, keeping its sign
`timescale 1ns/1ps
`default_nettype none
module ptj_clamp #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] value_in,
    input  wire logic [W-1:0] limit_in,
    output var  logic [W-1:0] value_out
);
    logic [W-1:0] mag;

    // magnitude compare and re-signing
    always_comb begin
        mag = value_in[W-1] ? W'(-value_in) : value_in;
        if (mag > limit_in) begin
            value_out = value_in[W-1] ? W'(-limit_in) : limit_in;
        end else begin
            value_out = value_in;
        end
    end
endmodule // ptj_clamp
`default_nettype wire

// [hdl/ptj_setup.sv]
// profile target, speed, scaling and jerk limitation setup of the drive
//
// Contract
// RULE_01: new scaling applies only when the numerator is written, never on denominator.
// RULE_02: numerator is signed 32 bit, accepts 1 to 2147483647, resets to 1.
// RULE_03: user position limits may shrink once the scaling factor is computed.
// RULE_04: profile position speed takes 1..13200, default 60, clamped by both ceilings.
// RULE_05: absolute target range follows scaling and enabled software limit switches.
// RULE_06: while moving, motor-relative target adds to actual motor position.
// RULE_07: while moving, target-relative target adds to current movement target.
// RULE_08: relative moves may overrun user limits only from standstill.
// RULE_09: such an overrun first sets the current position implicitly to zero.
// RULE_10: profile velocity speed takes -13200..13200, clamped by both ceilings.
// RULE_11: jerk time is 16 bit: 0 off, or 1 to 128 ms powers of two, reset 0.
// RULE_12: jerk limiting smooths reference position at every ramp transition.
// RULE_13: jerk limiting acts in profile velocity, profile position, jog and homing.
// RULE_14: jerk time changes only while the mode is inactive (motion finished).
// RULE_15: illegal or in-motion jerk writes are refused, old value kept.
`timescale 1ns/1ps
`default_nettype none
`include "ptj_defs.svh"
module ptj_setup #(
    parameter int TICK_CYCLES = `PTJ_TICK_NS / `PTJ_CLK_NS,
    parameter int MEM_AW      = 7
) (
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    input  wire ptj_pkg::ptj_req_type par_req_in,
    output var  ptj_pkg::ptj_rsp_type par_rsp_out,
    input  wire logic                 motion_finished_in,
    input  wire ptj_pkg::ptj_mode_type op_mode_in,
    input  wire logic [31:0]          actual_pos_in,
    input  wire logic [31:0]          current_target_in,
    input  wire logic [15:0]          max_speed_in,
    input  wire logic [15:0]          profile_speed_ceiling_in,
    input  wire logic                 swlim_en_in,
    input  wire logic [31:0]          swlim_min_in,
    input  wire logic [31:0]          swlim_max_in,
    input  wire logic [31:0]          ref_pos_in,
    output var  logic [31:0]          scale_num_out,
    output var  logic [31:0]          scale_den_out,
    output var  logic                 scale_apply_out,
    output var  logic [31:0]          user_lim_max_out,
    output var  logic [31:0]          user_lim_min_out,
    output var  logic [15:0]          pp_speed_out,
    output var  logic [15:0]          pv_speed_out,
    output var  logic [31:0]          target_pos_out,
    output var  logic                 move_start_out,
    output var  logic                 set_pos_zero_out,
    output var  logic [15:0]          jerk_time_out,
    output var  logic [31:0]          ref_pos_smooth_out
);
    ptj_pkg::ptj_state_type s_r;
    ptj_pkg::ptj_state_type s_nxt;

    logic [31:0]       w;
    logic [31:0]       scl_max;
    logic [31:0]       lim_max_c;
    logic [31:0]       lim_min_c;
    logic [15:0]       spd_lim;
    logic [15:0]       pps_clamped;
    logic [15:0]       pvs_clamped;
    logic [31:0]       base;
    logic signed [32:0] cand;
    logic              cand_ok;
    logic              rel_ok;
    logic              jerk_ok;
    logic              jerk_act;
    logic [4:0]        jshift;
    logic [31:0]       old_smp;
    logic              tick;
    logic              is_rel;

    assign w = par_req_in.wdata;

    // user limits from the scaling factor and the software limit switches
    always_comb begin
        if (s_r.num > s_r.den) begin
            scl_max = `PTJ_POS_MAX >> ptj_pkg::ptj_msb(s_r.num); // RULE_03
        end else begin
            scl_max = `PTJ_POS_MAX;
        end
        lim_max_c = scl_max;
        lim_min_c = ~scl_max;
        if (swlim_en_in && ($signed(swlim_max_in) < $signed(lim_max_c))) begin
            lim_max_c = swlim_max_in; // RULE_05
        end
        if (swlim_en_in && ($signed(swlim_min_in) > $signed(lim_min_c))) begin
            lim_min_c = swlim_min_in; // RULE_05
        end
    end

    // the tighter of the maximum speed and the profile speed ceiling
    assign spd_lim = (max_speed_in < profile_speed_ceiling_in) ? max_speed_in
                                                               : profile_speed_ceiling_in;

    // profile position speed clamp
    ptj_clamp #(
        .W (16)
    ) u_pps_clamp (
        .value_in  (s_r.pps),
        .limit_in  (spd_lim),
        .value_out (pps_clamped)
    );

    // profile velocity speed clamp
    ptj_clamp #(
        .W (16)
    ) u_pvs_clamp (
        .value_in  (s_r.pvs),
        .limit_in  (spd_lim),
        .value_out (pvs_clamped)
    );

    // relative target arithmetic, overflow kept in the extra bit
    always_comb begin
        is_rel = (par_req_in.addr == `PTJ_ADDR_RELM); // motor-relative base selected
        if (is_rel) begin
            base = actual_pos_in; // RULE_06
        end else begin
            base = current_target_in; // RULE_07
        end
        cand    = $signed({base[31], base}) + $signed({w[31], w});
        cand_ok = (cand <= $signed({1'b0, s_r.lim_max}))
               && (cand >= $signed({s_r.lim_min[31], s_r.lim_min}));
        rel_ok  = ($signed(w) <= $signed(s_r.lim_max)) && ($signed(w) >= $signed(s_r.lim_min));
    end

    // jerk code check: zero or a single bit up to the top setting
    assign jerk_ok = (w[31:16] == 16'h0000) && (w[15:0] <= `PTJ_JERK_MAX)
                  && ((w[15:0] & (w[15:0] - 16'h0001)) == 16'h0000); // RULE_11

    // smoothing only in profile generator modes with a nonzero window
    assign jerk_act = (s_r.jerk != `PTJ_JERK_RST)
                   && ((op_mode_in == ptj_pkg::MODE_PV) || (op_mode_in == ptj_pkg::MODE_PP)
                    || (op_mode_in == ptj_pkg::MODE_JOG)
                    || (op_mode_in == ptj_pkg::MODE_HOME)); // RULE_13
    assign jshift = ptj_pkg::ptj_msb({16'h0000, s_r.jerk});
    assign tick   = (s_r.tick_cnt == 16'(TICK_CYCLES - 1));

    // window of past reference samples, one per millisecond
    ptj_delay_mem #(
        .W  (32),
        .AW (MEM_AW)
    ) u_delay_mem (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .wr_en_in    (tick),
        .wr_addr_in  (s_r.wptr),
        .wr_data_in  (ref_pos_in),
        .rd_addr_in  (7'(s_r.wptr - 7'(s_r.jerk))),
        .rd_data_out (old_smp)
    );

    // next state: parameter access, target generation and jerk filter
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp.ack   = 1'b0;
        s_nxt.rsp.err   = 1'b0;
        s_nxt.apply     = 1'b0;
        s_nxt.start     = 1'b0;
        s_nxt.zero      = 1'b0;
        s_nxt.lim_max   = lim_max_c;
        s_nxt.lim_min   = lim_min_c;
        s_nxt.pps_eff   = pps_clamped; // RULE_04
        s_nxt.pvs_eff   = pvs_clamped; // RULE_10
        if (par_req_in.wr) begin
            s_nxt.rsp.ack = 1'b1;
            case (par_req_in.addr)
                `PTJ_ADDR_NUM: begin
                    if ($signed(w) > 0) begin // RULE_02
                        s_nxt.num   = w;
                        s_nxt.apply = 1'b1; // RULE_01
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                `PTJ_ADDR_DEN: begin
                    if ($signed(w) > 0) begin
                        s_nxt.den = w; // RULE_01
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                `PTJ_ADDR_JERK: begin
                    if (jerk_ok && motion_finished_in) begin // RULE_14
                        s_nxt.jerk = w[15:0];
                    end else begin
                        s_nxt.rsp.err = 1'b1; // RULE_15
                    end
                end
                `PTJ_ADDR_PPS: begin
                    if ((w >= `PTJ_PPS_MIN) && (w <= `PTJ_SPD_MAX)) begin // RULE_04
                        s_nxt.pps = w[15:0];
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                `PTJ_ADDR_PVS: begin
                    if (($signed(w) >= $signed(`PTJ_SPD_NEG))
                            && ($signed(w) <= $signed(`PTJ_SPD_MAX))) begin // RULE_10
                        s_nxt.pvs = w[15:0];
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                `PTJ_ADDR_ABS: begin
                    if (($signed(w) <= $signed(s_r.lim_max))
                            && ($signed(w) >= $signed(s_r.lim_min))) begin // RULE_05
                        s_nxt.abs_t  = w;
                        s_nxt.target = w;
                        s_nxt.start  = 1'b1;
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                `PTJ_ADDR_RELM, `PTJ_ADDR_RELT: begin
                    if (is_rel) begin
                        s_nxt.relm = w;
                    end else begin
                        s_nxt.relt = w;
                    end
                    if (cand_ok) begin
                        s_nxt.target = 32'(cand); // RULE_06 RULE_07
                        s_nxt.start  = 1'b1;
                    end else if (motion_finished_in && rel_ok) begin // RULE_08
                        s_nxt.zero   = 1'b1; // RULE_09
                        s_nxt.target = w;
                        s_nxt.start  = 1'b1;
                    end else begin
                        s_nxt.rsp.err = 1'b1;
                    end
                end
                default: begin
                    s_nxt.rsp.err = 1'b1;
                end
            endcase
        end else if (par_req_in.rd) begin
            s_nxt.rsp.ack = 1'b1;
            case (par_req_in.addr)
                `PTJ_ADDR_NUM:  s_nxt.rsp.rdata = s_r.num;
                `PTJ_ADDR_DEN:  s_nxt.rsp.rdata = s_r.den;
                `PTJ_ADDR_JERK: s_nxt.rsp.rdata = {16'h0000, s_r.jerk};
                `PTJ_ADDR_PPS:  s_nxt.rsp.rdata = {16'h0000, s_r.pps};
                `PTJ_ADDR_PVS:  s_nxt.rsp.rdata = {{16{s_r.pvs[15]}}, s_r.pvs};
                `PTJ_ADDR_ABS:  s_nxt.rsp.rdata = s_r.abs_t;
                `PTJ_ADDR_RELM: s_nxt.rsp.rdata = s_r.relm;
                `PTJ_ADDR_RELT: s_nxt.rsp.rdata = s_r.relt;
                `PTJ_ADDR_STAT: s_nxt.rsp.rdata = {30'h0000_0000, jerk_act, motion_finished_in};
                `PTJ_ADDR_TGT:  s_nxt.rsp.rdata = s_r.target;
                `PTJ_ADDR_LMAX: s_nxt.rsp.rdata = s_r.lim_max;
                `PTJ_ADDR_LMIN: s_nxt.rsp.rdata = s_r.lim_min;
                default: begin
                    s_nxt.rsp.rdata = 32'h0000_0000;
                    s_nxt.rsp.err   = 1'b1;
                end
            endcase
        end
        // millisecond sample tick and moving average over the jerk window
        s_nxt.tick_cnt = tick ? 16'h0000 : 16'(s_r.tick_cnt + 16'h0001);
        if (tick) begin
            s_nxt.wptr = 7'(s_r.wptr + 7'h01);
            if (!jerk_act || motion_finished_in) begin
                // standstill or bypass: preload window
                s_nxt.sum    = $signed({{8{ref_pos_in[31]}}, ref_pos_in}) <<< jshift;
                s_nxt.smooth = ref_pos_in;
            end else begin
                s_nxt.sum    = s_r.sum + $signed({{8{ref_pos_in[31]}}, ref_pos_in})
                             - $signed({{8{old_smp[31]}}, old_smp}); // RULE_12
                s_nxt.smooth = 32'(s_nxt.sum >>> jshift); // RULE_12
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_r          <= '0;
            s_r.num      <= `PTJ_NUM_RST; // RULE_02
            s_r.den      <= `PTJ_DEN_RST;
            s_r.jerk     <= `PTJ_JERK_RST; // RULE_11
            s_r.pps      <= `PTJ_PPS_RST; // RULE_04
            s_r.pps_eff  <= `PTJ_PPS_RST;
            s_r.lim_max  <= `PTJ_POS_MAX;
            s_r.lim_min  <= ~`PTJ_POS_MAX;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign par_rsp_out        = s_r.rsp;
    assign scale_num_out      = s_r.num;
    assign scale_den_out      = s_r.den;
    assign scale_apply_out    = s_r.apply;
    assign user_lim_max_out   = s_r.lim_max;
    assign user_lim_min_out   = s_r.lim_min;
    assign pp_speed_out       = s_r.pps_eff;
    assign pv_speed_out       = s_r.pvs_eff;
    assign target_pos_out     = s_r.target;
    assign move_start_out     = s_r.start;
    assign set_pos_zero_out   = s_r.zero;
    assign jerk_time_out      = s_r.jerk;
    assign ref_pos_smooth_out = s_r.smooth;
endmodule // ptj_setup
`default_nettype wire

// [verification/ptj_master.sv]
// fieldbus master model that issues single parameter accesses
`timescale 1ns/1ps
`default_nettype none
module ptj_master (
    input  wire logic                 clk_in,
    input  wire ptj_pkg::ptj_rsp_type par_rsp_out,
    output var  ptj_pkg::ptj_req_type par_req_in
);
    ptj_pkg::ptj_rsp_type last_rsp;
    // request lines start idle
    initial begin
        par_req_in = '0;
        last_rsp   = '0;
    end
    // one access, answer taken while ack stands; released bus shows inverse
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
        @(negedge clk_in);
        par_req_in = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(negedge clk_in);
        last_rsp   = par_rsp_out;
        par_req_in = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    endtask
endmodule // ptj_master
`default_nettype wire

// [verification/ptj_setup_assertions.sv]
// concurrent checks on the ports of the profile setup block
`timescale 1ns/1ps
`default_nettype none
`include "ptj_defs.svh"
module ptj_setup_assertions (
    input wire logic                 clk_in,
    input wire logic                 reset_n_in,
    input wire ptj_pkg::ptj_req_type par_req_in,
    input wire ptj_pkg::ptj_rsp_type par_rsp_out,
    input wire logic                 motion_finished_in,
    input wire logic [15:0]          max_speed_in,
    input wire logic [31:0]          scale_num_out,
    input wire logic                 scale_apply_out,
    input wire logic [15:0]          pp_speed_out,
    input wire logic                 move_start_out,
    input wire logic                 set_pos_zero_out,
    input wire logic [15:0]          jerk_time_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // a numerator write with a legal value
    sequence num_write_s;
        par_req_in.wr && par_req_in.addr == `PTJ_ADDR_NUM && $signed(par_req_in.wdata) > 0;
    endsequence
    // accepted answer together with the apply pulse
    sequence apply_s;
        scale_apply_out && par_rsp_out.ack && !par_rsp_out.err;
    endsequence
    a_num_apply: assert property (num_write_s |=> apply_s)
        else $error("numerator write without apply pulse");
    a_apply_cause: assert property (scale_apply_out |-> $past(par_req_in.wr)
        && $past(par_req_in.addr) == `PTJ_ADDR_NUM)
        else $error("apply pulse without numerator write");
    a_num_value: assert property (num_write_s |=> scale_num_out == $past(par_req_in.wdata))
        else $error("numerator not stored");
    a_num_range: assert property ($signed(scale_num_out) > 0)
        else $error("numerator out of range");
    a_ack_timing: assert property ((par_req_in.wr || par_req_in.rd) |=> par_rsp_out.ack)
        else $error("access not answered after one cycle");
    a_jerk_legal: assert property (jerk_time_out inside {16'h0000, 16'h0001, 16'h0002,
        16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0040, 16'h0080})
        else $error("jerk time holds an illegal code");
    a_jerk_frozen: assert property (!motion_finished_in |=> $stable(jerk_time_out))
        else $error("jerk time changed during motion");
    a_jerk_refuse: assert property (par_req_in.wr && par_req_in.addr == `PTJ_ADDR_JERK
        && !motion_finished_in |=> par_rsp_out.err)
        else $error("jerk write in motion not refused");
    a_pp_clamp: assert property (pp_speed_out <= $past(max_speed_in))
        else $error("profile position speed above maximum");
    a_zero_pair: assert property (set_pos_zero_out |-> move_start_out
        && $past(motion_finished_in))
        else $error("position zeroing outside a standstill start");
    a_start_cause: assert property (move_start_out |-> $past(par_req_in.wr)
        && !par_rsp_out.err)
        else $error("move start without accepted target write");
endmodule // ptj_setup_assertions
bind ptj_setup ptj_setup_assertions u_chk (.*);
`default_nettype wire

// [verification/tb_ptj_setup.sv]
// self-checking bench of the profile target and jerk setup block
`timescale 1ns/1ps
`default_nettype none
`include "ptj_defs.svh"
module tb_ptj_setup;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        err;
        logic [31:0] rdata;
    } ptj_row_type;
    logic clk_in, reset_n_in, motion_finished_in, swlim_en_in;
    logic scale_apply_out, move_start_out, set_pos_zero_out;
    logic [15:0] max_speed_in, profile_speed_ceiling_in, pp_speed_out, pv_speed_out, jerk_time_out;
    logic [31:0] actual_pos_in, current_target_in, swlim_min_in, swlim_max_in, ref_pos_in;
    logic [31:0] scale_num_out, scale_den_out, user_lim_max_out, user_lim_min_out;
    logic [31:0] target_pos_out, ref_pos_smooth_out;
    ptj_pkg::ptj_req_type  par_req_in;
    ptj_pkg::ptj_rsp_type  par_rsp_out;
    ptj_pkg::ptj_mode_type op_mode_in;
    ptj_pkg::ptj_mode_type modes [0:4] = '{ptj_pkg::MODE_PP, ptj_pkg::MODE_JOG,
        ptj_pkg::MODE_PV, ptj_pkg::MODE_HOME, ptj_pkg::MODE_NONE};
    int n_mismatch, check_count, cycles;
    // access rows: expected err and rdata
    ptj_row_type rows [0:17] = '{
        '{1'b0, `PTJ_ADDR_NUM, 32'h0, 1'b0, `PTJ_NUM_RST},
        '{1'b0, `PTJ_ADDR_JERK, 32'h0, 1'b0, 32'h0},
        '{1'b0, `PTJ_ADDR_PPS, 32'h0, 1'b0, 32'h0000_003C},
        '{1'b0, `PTJ_ADDR_DEN, 32'h0, 1'b0, `PTJ_DEN_RST},
        '{1'b1, `PTJ_ADDR_NUM, 32'h0, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_NUM, 32'hFFFF_FFFF, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_DEN, 32'h0, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_JERK, 32'h3, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_JERK, 32'h0001_0080, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_PPS, 32'h0, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_PPS, `PTJ_SPD_MAX, 1'b0, 32'h0},
        '{1'b1, `PTJ_ADDR_PPS, 32'h0000_3391, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_PVS, 32'h0000_3391, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_PVS, 32'hFFFF_CC6F, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_PVS, `PTJ_SPD_NEG, 1'b0, 32'h0},
        '{1'b0, `PTJ_ADDR_PVS, 32'h0, 1'b0, `PTJ_SPD_NEG},
        '{1'b0, 16'h0700, 32'h0, 1'b1, 32'h0},
        '{1'b1, `PTJ_ADDR_STAT, 32'h0, 1'b1, 32'h0}};
    ptj_setup #(.TICK_CYCLES(4)) u_dut (.*);
    ptj_master u_master (.*);
    // compare one value and count it
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // master write, then error flag check
    task automatic acc(input logic [15:0] a, input logic [31:0] d, input logic e);
        u_master.access(1'b1, a, d);
        check({31'h0, u_master.last_rsp.err}, {31'h0, e}, "err");
    endtask
    // closing report and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // clock of 100 ns
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // main sequence
    initial begin
        reset_n_in = 1'b0; motion_finished_in = 1'b1; swlim_en_in = 1'b0;
        op_mode_in = ptj_pkg::MODE_NONE; actual_pos_in = 32'h0; current_target_in = 32'h0;
        max_speed_in = 16'hFFFF; profile_speed_ceiling_in = 16'hFFFF; ref_pos_in = 32'h0;
        swlim_min_in = 32'h0; swlim_max_in = 32'h0;
        repeat (6) @(negedge clk_in);
        reset_n_in = 1'b1;
        @(negedge clk_in);
        check(scale_num_out, `PTJ_NUM_RST, "num rst");
        check({16'h0, jerk_time_out}, 32'h0, "jerk rst");
        check({16'h0, pp_speed_out}, 32'h0000_003C, "pps rst");
        check(user_lim_max_out, `PTJ_POS_MAX, "lmax rst");
        check(user_lim_min_out, ~`PTJ_POS_MAX, "lmin rst");
        $display("reset test done");
        foreach (rows[i]) begin
            u_master.access(rows[i].wr, rows[i].addr, rows[i].wdata);
            check({31'h0, u_master.last_rsp.err}, {31'h0, rows[i].err}, "row err");
            if (!rows[i].wr) begin
                check(u_master.last_rsp.rdata, rows[i].rdata, "row rdata");
            end
        end
        $display("table test done");
        for (int i = 0; i < 9; i++) begin
            acc(`PTJ_ADDR_JERK, (i == 0) ? 32'h0 : 32'h1 << (i - 1), 1'b0);
            check({16'h0, jerk_time_out}, (i == 0) ? 32'h0 : 32'h1 << (i - 1), "jerk");
        end
        motion_finished_in = 1'b0;
        acc(`PTJ_ADDR_JERK, 32'h4, 1'b1);
        check({16'h0, jerk_time_out}, 32'h0000_0080, "jerk kept");
        $display("jerk test done");
        acc(`PTJ_ADDR_NUM, 32'h5, 1'b0);
        check({31'h0, scale_apply_out}, 32'h1, "apply");
        repeat (2) @(negedge clk_in);
        check(user_lim_max_out, 32'h1FFF_FFFF, "narrow");
        acc(`PTJ_ADDR_DEN, 32'h3, 1'b0);
        check({31'h0, scale_apply_out}, 32'h0, "no apply");
        check(scale_den_out, 32'h3, "den");
        acc(`PTJ_ADDR_NUM, 32'h1, 1'b0);
        $display("scaling test done");
        max_speed_in = 16'h0064; profile_speed_ceiling_in = 16'h0032;
        repeat (2) @(negedge clk_in);
        check({16'h0, pp_speed_out}, 32'h0000_0032, "pps ceil");
        check({16'h0, pv_speed_out}, 32'h0000_FFCE, "pvs ceil");
        profile_speed_ceiling_in = 16'hFFFF;
        repeat (2) @(negedge clk_in);
        check({16'h0, pp_speed_out}, 32'h0000_0064, "pps max");
        $display("speed test done");
        actual_pos_in = 32'd1000; current_target_in = 32'd5000;
        acc(`PTJ_ADDR_RELM, 32'd25, 1'b0);
        check(target_pos_out, 32'd1025, "rel motor");
        check({30'h0, move_start_out, set_pos_zero_out}, 32'h2, "start");
        acc(`PTJ_ADDR_RELT, 32'hFFFF_FFF6, 1'b0);
        check(target_pos_out, 32'd4990, "rel target");
        swlim_en_in = 1'b1; swlim_min_in = 32'hFFFF_FF9C; swlim_max_in = 32'd100;
        actual_pos_in = 32'd90; current_target_in = 32'd90;
        repeat (2) @(negedge clk_in);
        check(user_lim_max_out, 32'd100, "sw lmax");
        check(user_lim_min_out, 32'hFFFF_FF9C, "sw lmin");
        acc(`PTJ_ADDR_ABS, 32'd200, 1'b1);
        acc(`PTJ_ADDR_ABS, 32'd100, 1'b0);
        check(target_pos_out, 32'd100, "abs");
        acc(`PTJ_ADDR_RELM, 32'd50, 1'b1);
        motion_finished_in = 1'b1;
        acc(`PTJ_ADDR_RELM, 32'd50, 1'b0);
        check({30'h0, move_start_out, set_pos_zero_out}, 32'h3, "zero");
        check(target_pos_out, 32'd50, "zero tgt");
        acc(`PTJ_ADDR_RELT, 32'd50, 1'b0);
        check({30'h0, move_start_out, set_pos_zero_out}, 32'h3, "zero");
        $display("target test done");
        acc(`PTJ_ADDR_JERK, 32'h2, 1'b0);
        motion_finished_in = 1'b0;
        foreach (modes[m]) begin
            op_mode_in = modes[m];
            ref_pos_in = 32'h0;
            repeat (16) @(negedge clk_in);
            ref_pos_in = 32'd100;
            for (int k = 0; k < 12 && ref_pos_smooth_out === 32'h0; k++) @(negedge clk_in);
            check(ref_pos_smooth_out, (m == 4) ? 32'd100 : 32'd50, "smooth");
        end
        $display("smoothing test done");
        give_verdict();
    end
endmodule // tb_ptj_setup
`default_nettype wire
